// *** hdl/upl_consts.svh ***
`ifndef UPL_CONSTS_SVH
`define UPL_CONSTS_SVH
`define UPL_ADDR_P2_GAIN 8'h13
`define UPL_ADDR_P3_FTW0 8'h14
`define UPL_ADDR_P3_FTW1 8'h15
`define UPL_ADDR_P3_FTW2 8'h16
`define UPL_ADDR_P3_FTW3 8'h17
`define UPL_ADDR_P3_CTRL 8'h18
`define UPL_ADDR_P3_GAIN 8'h19
`define UPL_RATE_LSB 2
`define UPL_RATE_MSB 7
`define UPL_BIT_SPEC_INV 1
`define UPL_BIT_ICIC_BYP 0
`define UPL_RATE_BYPASS 6'h01
`define UPL_LAT_ASM_MOD 4
`define UPL_LAT_ASM_INT 8
`define UPL_LAT_ICIC 12
`define UPL_LAT_FIXED 72
`define UPL_LAT_PROG_MUL 5
`define UPL_LAT_PROG_ADD 9
`define UPL_LAT_QMOD 7
`define UPL_LAT_ISINC 7
`define UPL_LAT_SCALE 6
`define UPL_HOP_FULL 30
`define UPL_HOP_NOSINC 24
`define UPL_ASM_STAGES 3
`endif

// *** hdl/upl_pkg.sv ***
package upl_pkg;
	typedef enum logic [2:0] {
		UPL_MODE_QMOD = 3'b001,
		UPL_MODE_TONE = 3'b010,
		UPL_MODE_IDAC = 3'b100
	} upl_mode_type;
	typedef struct packed {
		logic [31:0] tuning;
		logic [5:0] rate;
		logic spec_inv;
		logic icic_bypass;
		logic [7:0] gain;
	} upl_profile_type;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} upl_regreq_type;
endpackage : upl_pkg

// *** hdl/upl_clkdiv.sv ***
`timescale 1ns/1ps
`include "upl_consts.svh"
module upl_clkdiv (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [5:0] factor,
	output logic divided_rate_clock,
	output logic half_divided_clock,
	output logic quarter_divided_clock,
	output logic half_rise,
	output logic quarter_rise
);
	import upl_pkg::*;
	logic [5:0] count;
	logic div_pulse;
	// >= so a smaller factor written mid-count cannot run the counter round
	assign div_pulse = (count >= factor - 6'h01) || (factor <= 6'h01);
	assign half_rise = div_pulse && !half_divided_clock;
	assign quarter_rise = half_rise && !quarter_divided_clock;
	// divided clock is a one-cycle tick per N; a flop cannot run at core rate itself
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count <= 6'h00;
			divided_rate_clock <= 1'b0;
			half_divided_clock <= 1'b0;
			quarter_divided_clock <= 1'b0;
		end else begin
			count <= div_pulse ? 6'h00 : count + 6'h01;
			divided_rate_clock <= div_pulse;
			if (div_pulse) begin
				half_divided_clock <= !half_divided_clock;
				if (!half_divided_clock) begin
					quarter_divided_clock <= !quarter_divided_clock;
				end
			end
		end
	end
endmodule : upl_clkdiv

// *** hdl/upl_regfile.sv ***
`timescale 1ns/1ps
`include "upl_consts.svh"
module upl_regfile (
	input wire logic clk,
	input wire upl_pkg::upl_regreq_type req,
	output logic [7:0] rdata,
	output upl_pkg::upl_profile_type prof2,
	output upl_pkg::upl_profile_type prof3
);
	import upl_pkg::*;
	// no reset: contents undefined until software writes them
	logic [7:0] mem [0:6];
	logic [2:0] idx;
	assign idx = 3'(req.addr - `UPL_ADDR_P2_GAIN);
	always_ff @(posedge clk) begin
		if (req.wr && req.addr >= `UPL_ADDR_P2_GAIN && req.addr <= `UPL_ADDR_P3_GAIN) begin
			mem[idx] <= req.wdata;
		end
		rdata <= (req.addr >= `UPL_ADDR_P2_GAIN && req.addr <= `UPL_ADDR_P3_GAIN)
			? mem[idx] : 8'h00;
	end
	assign prof2 = '{tuning: 32'h0000_0000, rate: 6'h01, spec_inv: 1'b0,
		icic_bypass: 1'b1, gain: mem[0]};
	assign prof3 = '{tuning: {mem[4], mem[3], mem[2], mem[1]},
		rate: mem[5][`UPL_RATE_MSB:`UPL_RATE_LSB],
		spec_inv: mem[5][`UPL_BIT_SPEC_INV],
		icic_bypass: mem[5][`UPL_BIT_ICIC_BYP], gain: mem[6]};
endmodule : upl_regfile

// *** hdl/upl_path.sv ***
`timescale 1ns/1ps
`include "upl_consts.svh"
module upl_path (
	input wire logic clk,
	input wire logic resetn,
	input wire upl_pkg::upl_regreq_type reg_req,
	output logic [7:0] reg_rdata,
	input wire upl_pkg::upl_mode_type mode,
	input wire logic inv_sinc_on,
	input wire logic scaler_on,
	input wire upl_pkg::upl_profile_type prof0,
	input wire upl_pkg::upl_profile_type prof1,
	input wire logic profile_select_low,
	input wire logic profile_select_high,
	input wire logic burst_start,
	input wire logic [13:0] data_in,
	output logic parallel_data_clock,
	output logic divided_rate_clock,
	output logic quarter_divided_clock,
	output logic [1:0] active_profile,
	output logic [5:0] interp_factor,
	output logic [12:0] path_latency,
	output logic [13:0] chain_sample,
	output logic chain_valid,
	output logic [31:0] tone_tuning,
	output logic [21:0] scaled_sample,
	output logic hop_done,
	output logic [4:0] hop_cycles,
	output logic late_phase
);
	import upl_pkg::*;
	upl_profile_type prof2;
	upl_profile_type prof3;
	upl_profile_type sel_prof;
	logic [2:0] ps_low_sync;
	logic [2:0] ps_high_sync;
	logic [1:0] ps_index;
	logic [1:0] next_profile;
	logic half_rise;
	logic quarter_rise;
	logic half_clk;
	logic [13:0] asm_pipe [0:`UPL_ASM_STAGES-1];
	logic [`UPL_ASM_STAGES-1:0] asm_valid;
	logic [13:0] asm_hold;
	logic asm_hold_valid;
	logic pair_slot;
	logic [4:0] hop_count;
	logic hop_busy;
	logic [4:0] hop_limit;
	logic [12:0] lat_asm;
	logic [12:0] lat_icic;
	logic [12:0] lat_fixed;
	logic [12:0] lat_prog;
	logic [12:0] lat_tail;

	// rate field decode used in both factor and latency terms
	function automatic logic [5:0] decode_factor(input logic [5:0] rate);
		decode_factor = (rate <= `UPL_RATE_BYPASS) ? 6'h01 : rate;
	endfunction : decode_factor

	upl_regfile u_regs (
		.clk(clk),
		.req(reg_req),
		.rdata(reg_rdata),
		.prof2(prof2),
		.prof3(prof3)
	);

	upl_clkdiv u_div (
		.clk(clk),
		.resetn(resetn),
		.factor(interp_factor),
		.divided_rate_clock(divided_rate_clock),
		.half_divided_clock(half_clk),
		.quarter_divided_clock(quarter_divided_clock),
		.half_rise(half_rise),
		.quarter_rise(quarter_rise)
	);

	// select pins cross in from outside: three flops, act when 2nd and 3rd agree
	assign ps_index = {ps_high_sync[2], ps_low_sync[2]};
	assign next_profile = ((ps_high_sync[1] == ps_high_sync[2]) &&
		(ps_low_sync[1] == ps_low_sync[2])) ? ps_index : active_profile;
	assign sel_prof = (active_profile == 2'h0) ? prof0 :
		(active_profile == 2'h1) ? prof1 :
		(active_profile == 2'h2) ? prof2 : prof3;
	assign interp_factor = decode_factor(sel_prof.rate);
	assign parallel_data_clock = half_clk;

	// latency model; figures are estimates and real flow may be data dependent
	assign lat_asm = (mode == UPL_MODE_QMOD) ?
		13'(`UPL_LAT_ASM_MOD * interp_factor) :
		13'(`UPL_LAT_ASM_INT * interp_factor);
	assign lat_icic = sel_prof.icic_bypass ? 13'h0000 :
		13'(`UPL_LAT_ICIC * interp_factor);
	assign lat_fixed = 13'(`UPL_LAT_FIXED * interp_factor);
	assign lat_prog = 13'(`UPL_LAT_PROG_MUL * interp_factor + `UPL_LAT_PROG_ADD);
	assign lat_tail = ((mode == UPL_MODE_QMOD) ? 13'(`UPL_LAT_QMOD) : 13'h0000) +
		(inv_sinc_on ? 13'(`UPL_LAT_ISINC) : 13'h0000) +
		(scaler_on ? 13'(`UPL_LAT_SCALE) : 13'h0000);
	assign hop_limit = inv_sinc_on ? 5'(`UPL_HOP_FULL - 1) : 5'(`UPL_HOP_NOSINC - 1);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ps_low_sync <= 3'h0;
			ps_high_sync <= 3'h0;
			active_profile <= 2'h0;
			path_latency <= 13'h0000;
		end else begin
			ps_low_sync <= {ps_low_sync[1:0], profile_select_low};
			ps_high_sync <= {ps_high_sync[1:0], profile_select_high};
			// tone mode samples on core clock, else on data clock rising edge
			if (mode == UPL_MODE_TONE || half_rise) begin
				active_profile <= next_profile;
			end
			path_latency <= lat_asm + lat_icic + lat_fixed + lat_prog + lat_tail;
		end
	end

	// three-stage assembler pipe on the data clock
	genvar g;
	generate
		for (g = 0; g < `UPL_ASM_STAGES; g = g + 1) begin : g_asm
			always_ff @(posedge clk) begin
				if (!resetn) begin
					asm_pipe[g] <= 14'h0000;
					asm_valid[g] <= 1'b0;
				end else if (half_rise) begin
					asm_pipe[g] <= (g == 0) ? data_in : asm_pipe[(g == 0) ? 0 : g - 1];
					// no end-of-burst input, so a started stream stays valid until reset
					asm_valid[g] <= (g == 0) ? (burst_start || asm_valid[0]) :
						asm_valid[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate

	// assembler output held a whole pair slot, so either start phase keeps its word
	always_ff @(posedge clk) begin
		if (!resetn) begin
			asm_hold <= 14'h0000;
			asm_hold_valid <= 1'b0;
			chain_sample <= 14'h0000;
			chain_valid <= 1'b0;
			pair_slot <= 1'b0;
			late_phase <= 1'b0;
		end else begin
			if (half_rise && burst_start) begin
				// lowering start phase costs one extra data clock
				late_phase <= quarter_divided_clock;
			end
			chain_valid <= 1'b0;
			if (quarter_rise && asm_hold_valid) begin
				chain_sample <= asm_hold;
				chain_valid <= 1'b1;
				asm_hold_valid <= 1'b0;
			end
			if (half_rise) begin
				pair_slot <= asm_valid[`UPL_ASM_STAGES-1] && !pair_slot;
			end
			// a fresh word wins over the take in the same cycle
			if (half_rise && asm_valid[`UPL_ASM_STAGES-1] && !pair_slot) begin
				asm_hold <= asm_pipe[`UPL_ASM_STAGES-1];
				asm_hold_valid <= 1'b1;
			end
		end
	end

	// tone hop: new word applies at once, settle counter bounds completion
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tone_tuning <= 32'h0000_0000;
			scaled_sample <= 22'h000000;
			hop_count <= 5'h00;
			hop_busy <= 1'b0;
			hop_done <= 1'b0;
			hop_cycles <= 5'h00;
		end else begin
			tone_tuning <= sel_prof.tuning;
			// 8-bit gain is u1.7, so product keeps seven fraction bits
			scaled_sample <= scaler_on ? 22'(chain_sample) * 22'(sel_prof.gain) :
				{1'b0, chain_sample, 7'h00};
			hop_done <= 1'b0;
			if (mode == UPL_MODE_TONE && next_profile != active_profile) begin
				hop_busy <= 1'b1;
				hop_count <= 5'h00;
			end else if (hop_busy) begin
				hop_count <= hop_count + 5'h01;
				if (hop_count == hop_limit - 5'h01) begin
					hop_busy <= 1'b0;
					hop_done <= 1'b1;
					hop_cycles <= hop_count + 5'h01;
				end
			end
		end
	end
endmodule : upl_path

// *** verif/upl_path_chk.sv ***
`timescale 1ns/1ps
module upl_path_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire upl_pkg::upl_regreq_type reg_req,
	input wire logic [7:0] reg_rdata,
	input wire upl_pkg::upl_mode_type mode,
	input wire logic inv_sinc_on,
	input wire upl_pkg::upl_profile_type prof0,
	input wire logic profile_select_low,
	input wire logic profile_select_high,
	input wire logic parallel_data_clock,
	input wire logic quarter_divided_clock,
	input wire logic [1:0] active_profile,
	input wire logic [5:0] interp_factor,
	input wire logic chain_valid,
	input wire logic hop_done,
	input wire logic [4:0] hop_cycles,
	input wire logic late_phase
);
	import upl_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic [1:0] sel = {profile_select_high, profile_select_low};
	wire logic mapped = reg_req.addr inside {[8'h13:8'h19]};
	a_factor_range: assert property (interp_factor inside {[6'h01:6'h3f]})
		else $error("factor out of range");
	a_rate_decode: assert property (active_profile == 2'h0 && $stable(prof0) |->
		interp_factor == ((prof0.rate < 6'h02) ? 6'h01 : prof0.rate)) else $error("bad factor");
	a_reg_readback: assert property (reg_req.wr && mapped ##1 $stable(reg_req.addr) |=>
		reg_rdata == $past(reg_req.wdata, 2)) else $error("readback wrong");
	a_unmapped_zero: assert property (!mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_quarter_edge: assert property ($changed(quarter_divided_clock) |->
		$rose(parallel_data_clock)) else $error("quarter moved off half rise");
	a_hop_bound: assert property (hop_done |->
		hop_cycles < (inv_sinc_on ? 5'h1e : 5'h18)) else $error("hop too slow");
	a_chain_pulse: assert property (chain_valid |=> !chain_valid)
		else $error("chain valid too long");
	a_select_index: assert property ((mode == UPL_MODE_TONE && $stable(sel))[*6] |->
		active_profile == sel) else $error("wrong profile");
	c_hop: cover property (hop_done);
	c_late: cover property (chain_valid && late_phase);
	c_early: cover property (chain_valid && !late_phase);
endmodule : upl_path_chk
bind upl_path upl_path_chk i_chk (.clk, .resetn, .reg_req, .reg_rdata, .mode, .inv_sinc_on,
	.prof0, .profile_select_low, .profile_select_high, .parallel_data_clock,
	.quarter_divided_clock, .active_profile, .interp_factor, .chain_valid, .hop_done,
	.hop_cycles, .late_phase);

// *** verif/upl_bb_src.sv ***
`timescale 1ns/1ps
module upl_bb_src (
	input wire logic clk,
	input wire logic parallel_data_clock,
	input wire logic enable,
	output logic [13:0] data_in,
	output logic burst_start
);
	logic prev = 1'b0;
	logic first = 1'b1;
	initial data_in = 14'h0000;
	initial burst_start = 1'b0;
	// change just after the rise so the word holds over the next capture
	always @(posedge clk) begin
		prev <= parallel_data_clock;
		if (parallel_data_clock && !prev) begin
			data_in <= #1 enable ? data_in + 14'h0001 : ~data_in;
			burst_start <= #1 enable && first;
			first <= !enable;
		end
	end
endmodule : upl_bb_src

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD %0t got %0h want %0h", $time, a, b); end end
module testbench;
	import upl_pkg::*;
	typedef struct packed {
		upl_mode_type m;
		logic s, c, b;
		logic [5:0] r;
		logic [12:0] lat;
	} upl_row_type;
	upl_row_type rows [5] = '{
		'{UPL_MODE_QMOD, 1'b0, 1'b0, 1'b1, 6'h02, 13'h0b2},
		'{UPL_MODE_IDAC, 1'b0, 1'b1, 1'b0, 6'h14, 13'h7a3},
		'{UPL_MODE_QMOD, 1'b1, 1'b1, 1'b0, 6'h01, 13'h07a},
		'{UPL_MODE_IDAC, 1'b1, 1'b0, 1'b1, 6'h3f, 13'h14fb},
		'{UPL_MODE_QMOD, 1'b0, 1'b0, 1'b1, 6'h00, 13'h061}};
	logic clk = 1'b0, resetn = 1'b0, inv_sinc_on = 1'b0, scaler_on = 1'b0, src_en = 1'b0;
	logic profile_select_low = 1'b0, profile_select_high = 1'b0;
	upl_regreq_type reg_req = '0;
	upl_mode_type mode = UPL_MODE_QMOD;
	upl_profile_type prof0 = '0, prof1 = '0;
	logic [7:0] reg_rdata, d;
	logic [13:0] data_in, chain_sample;
	logic [1:0] active_profile;
	logic [5:0] interp_factor;
	logic [12:0] path_latency;
	logic [31:0] tone_tuning;
	logic [21:0] scaled_sample;
	logic [4:0] hop_cycles;
	logic burst_start, parallel_data_clock, divided_rate_clock, quarter_divided_clock;
	logic chain_valid, hop_done, late_phase;
	logic pp;
	logic [13:0] w;
	int n, pd, dv, qd, cv, cycles, num_errors, compares;
	upl_path i_dut (.clk, .resetn, .reg_req, .reg_rdata, .mode, .inv_sinc_on, .scaler_on,
		.prof0, .prof1, .profile_select_low, .profile_select_high, .burst_start, .data_in,
		.parallel_data_clock, .divided_rate_clock, .quarter_divided_clock, .active_profile,
		.interp_factor, .path_latency, .chain_sample, .chain_valid, .tone_tuning,
		.scaled_sample, .hop_done, .hop_cycles, .late_phase);
	upl_bb_src i_src (.clk, .parallel_data_clock, .enable(src_en), .data_in, .burst_start);
	always #10 clk = ~clk;
	task tally_and_finish;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_req = '{1'b1, a, v};
		step(1);
		reg_req.wr = 1'b0;
		step(1);
	endtask : wr
	task rd(input logic [7:0] a);
		reg_req = '{1'b0, a, 8'h00};
		step(1);
		d = reg_rdata;
	endtask : rd
	task hop(input logic [1:0] s);
		{profile_select_high, profile_select_low} = s;
		n = 0;
		while (hop_done !== 1'b1 && n < 40) begin
			step(1);
			n++;
		end
		`CHK(hop_done, 1'b1)
	endtask : hop
	initial begin
		step(20);
		resetn = 1'b1;
		step(2);
		`CHK(active_profile, 2'h0)
		prof0.gain = 8'h40;
		foreach (rows[i]) begin
			mode = rows[i].m;
			{inv_sinc_on, scaler_on, prof0.icic_bypass, prof0.rate} = rows[i][21:13];
			step(6);
			`CHK(path_latency, rows[i].lat)
			`CHK(interp_factor, (rows[i].r < 6'h02) ? 6'h01 : rows[i].r)
		end
		// n = 2: data clock period 4, sampling period 8
		mode = UPL_MODE_QMOD;
		prof0.rate = 6'h02;
		scaler_on = 1'b1;
		src_en = 1'b1;
		n = 0;
		do begin
			pp = parallel_data_clock;
			step(1);
			n++;
		end while (!(parallel_data_clock && !pp && burst_start) && n < 60);
		w = data_in;
		n = 0;
		while (chain_valid !== 1'b1 && n < 40) begin
			step(1);
			n++;
		end
		// four data clocks from the raising start phase, five from the lowering one
		`CHK(n, late_phase ? 20 : 16)
		`CHK(chain_sample, w)
		step(1);
		`CHK(scaled_sample, 22'(w) * 22'h000040)
		for (int i = 0; i < 80; i++) begin
			step(1);
			pd += parallel_data_clock;
			dv += divided_rate_clock;
			qd += quarter_divided_clock;
			cv += chain_valid;
		end
		`CHK(pd, 40)
		`CHK(dv, 40)
		`CHK(qd, 40)
		`CHK(cv, 10)
		src_en = 1'b0;
		for (int a = 8'h13; a <= 8'h1a; a++) wr(8'(a), 8'(a) ^ 8'h5a);
		for (int a = 8'h13; a <= 8'h1a; a++) begin
			rd(8'(a));
			`CHK(d, (a == 8'h1a) ? 8'h00 : 8'(a) ^ 8'h5a)
		end
		for (int i = 0; i < 4; i++) wr(8'h14 + 8'(i), 8'(32'h12345678 >> (8 * i)));
		mode = UPL_MODE_TONE;
		inv_sinc_on = 1'b1;
		step(10);
		hop(2'b11);
		`CHK(hop_cycles < 5'h1e, 1'b1)
		step(2);
		`CHK(active_profile, 2'h3)
		`CHK(tone_tuning, 32'h12345678)
		inv_sinc_on = 1'b0;
		step(4);
		hop(2'b10);
		`CHK(hop_cycles < 5'h18, 1'b1)
		step(2);
		`CHK(active_profile, 2'h2)
		// mid-run reset: clocks and status clear, profile comes back from the pins
		resetn = 1'b0;
		step(2);
		`CHK({parallel_data_clock, divided_rate_clock, quarter_divided_clock}, 3'h0)
		`CHK({chain_valid, late_phase}, 2'h0)
		`CHK(active_profile, 2'h0)
		resetn = 1'b1;
		step(8);
		`CHK(active_profile, 2'h2)
		tally_and_finish();
	end
endmodule : testbench
